// file: sdlcfs_top.v
/*
 Serial-bus fault supervisor: retry/latch of critical faults,
 detector fault filtering, message enables, permissive check,
 channel map and per-device frame error counts, over AXI4-Lite.
 Assumes all inputs synchronous to aclk; link framing is elsewhere.
*/
`timescale 1ns/1ns
`include "sdlcfs_regs.vh"
module sdlcfs_top #(
  parameter N_DEV = 17,
  parameter N_DET = 8,
  parameter ERR_W = 16,
  parameter CLK_HZ = `SFS_CLK_HZ
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Bus device health
  input wire [N_DEV-1:0] dev_comm_ok,
  input wire [N_DEV-1:0] dev_frame_err,
  input wire serial_interface_unit_fault,
  output wire [N_DEV-1:0] dev_poll_enable,
  // Detector units
  input wire [N_DET-1:0] det_fault_report,
  input wire [N_DET-1:0] det_watchdog_fault,
  output wire [N_DET-1:0] det_event,
  output wire [N_DET-1:0] det_reset,
  // Message scheduling
  input wire slow_msg_request,
  output wire slow_msg_send,
  input wire frame0_slot,
  input wire [23:0] out_chan_state,
  output wire frame0_send,
  output wire [15:0] frame0_chan,
  output wire tod_send,
  // Monitor unit
  input wire mmu_present,
  input wire [119:0] mmu_perm_cfg,
  // Fault outputs
  output wire critical_fault,
  output wire flash,
  output wire chan_conflict
);

localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_FAULT = 4'b0010;
localparam [3:0] ST_WIN = 4'b0100;
localparam [3:0] ST_LATCH = 4'b1000;
localparam [31:0] TICK_MAX = CLK_HZ - 1;

////////////////////////////////////////////////////////////////////
// Register bus

reg [31:0] ctrl_q;
reg [N_DEV-1:0] deven_q;
reg [127:0] perm_q;
reg [127:0] map_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg rvalid_q;
reg [1:0] rresp_q;
reg [31:0] rdata_q;
reg [31:0] rd_d;
reg rd_ok;
reg clr_fault_q;
reg clr_err_q;
wire wen = awvalid & wvalid & ~bvalid_q;
wire ren = arvalid & ~rvalid_q;
wire w_cmd = wen && awaddr == `SFS_CMD && wstrb[0];
wire w_map = awaddr[7:4] == `SFS_MAP_PAGE;
wire w_perm = awaddr[7:4] == `SFS_PERM_PAGE;
wire w_known = awaddr == `SFS_CTRL || awaddr == `SFS_CMD ||
  awaddr == `SFS_DEVEN || w_map || w_perm;

assign awready = wen;
assign wready = wen;
assign bvalid = bvalid_q;
assign bresp = bresp_q;
assign arready = ~rvalid_q;
assign rvalid = rvalid_q;
assign rresp = rresp_q;
assign rdata = rdata_q;

function [31:0] wmerge;
  input [31:0] old;
  input [31:0] dat;
  input [3:0] strb;
  integer k;
  begin
    wmerge = old;
    for (k = 0; k < 4; k = k + 1)
      if (strb[k])
        wmerge[8*k +: 8] = dat[8*k +: 8];
  end
endfunction

wire [31:0] deven_wr = wmerge({{(32-N_DEV){1'b0}}, deven_q}, wdata, wstrb);

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    ctrl_q <= `SFS_CTRL_RST;
    deven_q <= {N_DEV{1'b0}};
    perm_q <= 128'h0;
    map_q <= 128'h0;
    bvalid_q <= 1'b0;
    bresp_q <= `SFS_RESP_OKAY;
    clr_fault_q <= 1'b0;
    clr_err_q <= 1'b0;
  end
  else
  begin
    clr_fault_q <= w_cmd & wdata[`SFS_CLR_FAULT_BIT];
    clr_err_q <= w_cmd & wdata[`SFS_CLR_ERR_BIT];
    if (bvalid_q && bready)
      bvalid_q <= 1'b0;
    if (wen)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= w_known ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
      if (awaddr == `SFS_CTRL)
        ctrl_q <= wmerge(ctrl_q, wdata, wstrb) & `SFS_CTRL_MASK; // [R1] [R6]
      if (awaddr == `SFS_DEVEN)
        deven_q <= deven_wr[N_DEV-1:0];
      if (w_perm)
        perm_q[{awaddr[3:2], 5'h00} +: 32] <=
          wmerge(perm_q[{awaddr[3:2], 5'h00} +: 32], wdata, wstrb); // [R15]
      if (w_map)
        map_q[{awaddr[3:2], 5'h00} +: 32] <=
          wmerge(map_q[{awaddr[3:2], 5'h00} +: 32], wdata, wstrb); // [R17]
    end
  end
end

////////////////////////////////////////////////////////////////////
// Settings and one-second tick

wire [7:0] retry_min = ctrl_q[`SFS_RETRY_LSB +: 8];
wire [1:0] det_mode = ctrl_q[`SFS_DETM_LSB +: 2];
wire run_on = ctrl_q[`SFS_RUN_BIT];
reg [31:0] tick_cnt_q;
wire tick = tick_cnt_q == TICK_MAX;

always @(posedge aclk)
begin
  if (!aresetn)
    tick_cnt_q <= 32'h0;
  else if (tick)
    tick_cnt_q <= 32'h0;
  else
    tick_cnt_q <= tick_cnt_q + 32'h1;
end

// Polling cadence at the bus rate is owned by the framer
assign dev_poll_enable = deven_q & {N_DEV{run_on}}; // [R19]
assign slow_msg_send = slow_msg_request & ~ctrl_q[`SFS_SLOW_BIT]; // [R10]

////////////////////////////////////////////////////////////////////
// Critical fault retry

reg [3:0] st_q;
reg [1:0] rec_cnt_q;
reg [7:0] min_q;
reg [5:0] sec_q;
wire comm_fault = (|(deven_q & ~dev_comm_ok) |
  serial_interface_unit_fault) & run_on; // [R7]
wire expired = min_q == 8'h00 && sec_q == 6'h00;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    st_q <= ST_IDLE;
    rec_cnt_q <= 2'h0;
    min_q <= 8'h00;
    sec_q <= 6'h00;
  end
  else
  begin
    if (tick && !expired)
    begin
      if (sec_q == 6'h00)
      begin
        min_q <= min_q - 8'h01;
        sec_q <= `SFS_SEC_PER_MIN;
      end
      else
        sec_q <= sec_q - 6'h01;
    end
    case (st_q)
      ST_IDLE:
        if (comm_fault)
        begin
          min_q <= retry_min; // [R1]
          sec_q <= 6'h00;
          rec_cnt_q <= 2'h1;
          st_q <= (retry_min == 8'h00) ? ST_LATCH : ST_FAULT; // [R2]
        end
      ST_FAULT:
        if (expired)
          st_q <= ST_LATCH;
        else if (!comm_fault)
          st_q <= ST_WIN; // [R3]
      ST_WIN:
        if (comm_fault)
        begin
          if (rec_cnt_q == `SFS_MAX_RECOVER)
            st_q <= ST_LATCH; // [R4]
          else
          begin
            rec_cnt_q <= rec_cnt_q + 2'h1;
            st_q <= ST_FAULT; // [R4]
          end
        end
        else if (expired)
        begin
          rec_cnt_q <= 2'h0; // [R20]
          st_q <= ST_IDLE;
        end
      ST_LATCH:
        if (clr_fault_q)
        begin
          rec_cnt_q <= 2'h0; // [R5]
          st_q <= ST_IDLE;
        end
      default:
        st_q <= ST_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////
// Permissive check and channel map

reg perm_fault_q;
reg frame0_send_q;
reg [15:0] frame0_chan_q;
reg tod_send_q;
wire [15:0] mmu_state;

sdlcfs_chanmap i_sdlcfs_chanmap (
  .out_state(out_chan_state),
  .map(map_q),
  .perm(perm_q[119:0]),
  .mmu_state(mmu_state),
  .conflict(chan_conflict)
);

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    perm_fault_q <= 1'b0;
    frame0_send_q <= 1'b0;
    frame0_chan_q <= 16'h0000;
    tod_send_q <= 1'b0;
  end
  else
  begin
    // Mismatch set wins over a clear in the same cycle
    if (mmu_present && mmu_perm_cfg != perm_q[119:0])
      perm_fault_q <= 1'b1; // [R14]
    else if (clr_fault_q)
      perm_fault_q <= 1'b0;
    frame0_send_q <= frame0_slot & ctrl_q[`SFS_MSG0_BIT]; // [R11]
    if (frame0_slot && ctrl_q[`SFS_MSG0_BIT])
      frame0_chan_q <= mmu_state; // [R12]
    tod_send_q <= tick & ctrl_q[`SFS_TOD_BIT]; // [R13]
  end
end

assign frame0_send = frame0_send_q;
assign frame0_chan = frame0_chan_q;
assign tod_send = tod_send_q;
assign critical_fault = st_q == ST_LATCH;
assign flash = (st_q == ST_LATCH) | (st_q == ST_FAULT) | perm_fault_q; // [R14]

////////////////////////////////////////////////////////////////////
// Detector events and resets, error counts

wire [ERR_W*N_DEV-1:0] err_flat;

genvar g;
generate
  for (g = 0; g < N_DET; g = g + 1)
  begin : g_det
    reg ev_q;
    reg rst_q;
    reg [4:0] hold_q;
    wire fire = det_mode == `SFS_DET_ONRST && det_watchdog_fault[g] &&
      hold_q == 5'h00;
    always @(posedge aclk)
    begin
      if (!aresetn)
      begin
        ev_q <= 1'b0;
        rst_q <= 1'b0;
        hold_q <= 5'h00;
      end
      else
      begin
        ev_q <= det_fault_report[g] && det_mode != `SFS_DET_OFF; // [R8]
        rst_q <= fire; // [R9]
        // One tick spare, as the first decrement may fall at once
        if (fire)
          hold_q <= `SFS_DET_RST_GAP_S + 5'd1; // [R9]
        else if (tick && hold_q != 5'h00)
          hold_q <= hold_q - 5'h01;
      end
    end
    assign det_event[g] = ev_q;
    assign det_reset[g] = rst_q;
  end
  for (g = 0; g < N_DEV; g = g + 1)
  begin : g_err
    reg [ERR_W-1:0] cnt_q;
    wire hit = dev_frame_err[g] & deven_q[g];
    always @(posedge aclk)
    begin
      if (!aresetn)
        cnt_q <= {ERR_W{1'b0}};
      else if (clr_err_q)
        cnt_q <= {{(ERR_W-1){1'b0}}, hit}; // [R18]
      else if (hit && cnt_q != {ERR_W{1'b1}})
        cnt_q <= cnt_q + {{(ERR_W-1){1'b0}}, 1'b1}; // [R18]
    end
    assign err_flat[ERR_W*g +: ERR_W] = cnt_q;
  end
endgenerate

////////////////////////////////////////////////////////////////////
// Read path

wire [7:0] err_off = araddr - `SFS_ERR0;
wire [5:0] err_idx = err_off[7:2];

always @*
begin
  rd_d = 32'h0;
  rd_ok = 1'b1;
  case (araddr)
    `SFS_CTRL: rd_d = ctrl_q;
    `SFS_CMD: rd_d = 32'h0;
    `SFS_STAT: rd_d = {2'h0, sec_q, min_q, 6'h00, st_q, rec_cnt_q,
      flash, perm_fault_q, critical_fault, comm_fault};
    `SFS_DEVEN: rd_d[N_DEV-1:0] = deven_q;
    `SFS_DEVOK: rd_d[N_DEV-1:0] = dev_comm_ok & deven_q; // [R18]
    default:
      if (araddr[7:4] == `SFS_PERM_PAGE)
        rd_d = perm_q[{araddr[3:2], 5'h00} +: 32];
      else if (araddr[7:4] == `SFS_MAP_PAGE)
        rd_d = map_q[{araddr[3:2], 5'h00} +: 32];
      else if (araddr >= `SFS_ERR0 && err_idx < N_DEV && araddr[1:0] == 2'h0)
        rd_d[ERR_W-1:0] = err_flat[ERR_W*err_idx +: ERR_W];
      else
        rd_ok = 1'b0;
  endcase
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    rvalid_q <= 1'b0;
    rresp_q <= `SFS_RESP_OKAY;
    rdata_q <= 32'h0;
  end
  else if (ren)
  begin
    rvalid_q <= 1'b1;
    rresp_q <= rd_ok ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
    rdata_q <= rd_d;
  end
  else if (rready)
    rvalid_q <= 1'b0;
end

endmodule // sdlcfs_top

// file: sdlcfs_regs.vh
/*
 Register map, field positions, reset values and timing constants
 of the serial-bus fault supervisor.
 Assumes inclusion by bare name from the design files.
*/
// Notes on behaviour
// R1 - Retry countdown of 0 to 255 minutes starts on a critical bus fault.
// R2 - Retry time zero: any critical fault latches until power cycle or clear.
// R3 - Nonzero retry: fault mode lasts only until valid communication returns.
// R4 - Timer runs on after recovery; third fault before expiry latches.
// R5 - Latched fault never self-recovers; only reset or operator clear.
// R6 - Software should leave retry time at zero to trap first error.
// R7 - Serial interface unit faults use the same retry behaviour.
// R8 - Detector fault setting on: detector faults give events; off: none.
// R9 - On-with-reset: watchdog fault gives reset pulse, at most one per 20 s.
// R10 - Slow message suppress on blocks slow messages; off permits; off default.
// R11 - Frame zero enable on: device sends monitor frame zero itself.
// R12 - Frame zero carries channel states after monitor-to-output remapping.
// R13 - Time of day enabled: sent once every second; disabled: never.
// R14 - Permissive table differs from monitor setup: permissive fault, flash.
// R15 - Permissive table is triangular over channels 1-16, one bit per pair.
// R16 - Compatible pairs may show active indications together without conflict.
// R17 - Map each of 16 monitor channels to one of 24 outputs; 0 is one-to-one.
// R18 - Frame error count and status per enabled device; counts clearable.
// R19 - Enabled units are polled at 153.6 Kbps at once while run-timer is on.
// R20 - Timer expiry with no fault active clears the recoverable fault count.
`ifndef SDLCFS_REGS_VH
`define SDLCFS_REGS_VH

// Byte offsets and 16-byte page numbers
`define SFS_CTRL 8'h00
`define SFS_CMD 8'h04
`define SFS_STAT 8'h08
`define SFS_DEVEN 8'h0c
`define SFS_PERM_PAGE 4'h1
`define SFS_MAP_PAGE 4'h2
`define SFS_DEVOK 8'h30
`define SFS_ERR0 8'h40

// Control fields
`define SFS_RETRY_LSB 0
`define SFS_DETM_LSB 8
`define SFS_SLOW_BIT 10
`define SFS_MSG0_BIT 11
`define SFS_TOD_BIT 12
`define SFS_RUN_BIT 13
`define SFS_CTRL_RST 32'h0000_0100
`define SFS_CTRL_MASK 32'h0000_3fff

// Command bits
`define SFS_CLR_FAULT_BIT 0
`define SFS_CLR_ERR_BIT 1

// Detector fault modes
`define SFS_DET_OFF 2'h0
`define SFS_DET_ON 2'h1
`define SFS_DET_ONRST 2'h2

// Timing and recovery limit
`define SFS_CLK_HZ 20000000
`define SFS_SEC_PER_MIN 6'd59
`define SFS_DET_RST_GAP_S 5'd20
`define SFS_MAX_RECOVER 2'd2
`define SFS_BUS_BPS 153600

`define SFS_RESP_OKAY 2'b00
`define SFS_RESP_SLVERR 2'b10

`endif

// file: sdlcfs_chanmap.v
/*
 Monitor-to-output channel remap and permissive conflict check.
 Assumes out_state holds one active-indication bit per cabinet output.
*/
`timescale 1ns/1ns
module sdlcfs_chanmap (
  // Cabinet output indications
  input wire [23:0] out_state,
  // Map entries, 8 bits each, low 5 used
  input wire [127:0] map,
  // Triangular compatibility table
  input wire [119:0] perm,
  // Results
  output wire [15:0] mmu_state,
  output wire conflict
);

wire [119:0] clash;

genvar i, j;
generate
  for (i = 0; i < 16; i = i + 1)
  begin : g_ch
    wire [4:0] ent = map[8*i +: 5];
    wire [4:0] sel = ent - 5'h01;
    // Out-of-range entries fall back to one-to-one
    assign mmu_state[i] = (ent == 5'h00 || ent > 5'd24) ?
      out_state[i] : out_state[sel]; // [R17] [R12]
    for (j = i + 1; j < 16; j = j + 1)
    begin : g_pair
      localparam integer IDX = i * 15 - (i * (i - 1)) / 2 + (j - i - 1);
      assign clash[IDX] = mmu_state[i] & mmu_state[j] & ~perm[IDX]; // [R15] [R16]
    end
  end
endgenerate

assign conflict = |clash;

endmodule // sdlcfs_chanmap

// file: sdlcfs_checker_assertions.sv
/* Port checker for the serial-bus fault supervisor.
   Assumes one clock domain; bound onto sdlcfs_top below. */
`timescale 1ns/1ns
module sdlcfs_checker #(
  parameter N_DEV = 17,
  parameter N_DET = 8,
  parameter CLK_HZ = 20
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write bus
  input wire [7:0] awaddr,
  input wire awvalid,
  input wire awready,
  input wire [31:0] wdata,
  input wire wvalid,
  // Bus health
  input wire [N_DEV-1:0] dev_comm_ok,
  input wire [N_DEV-1:0] dev_poll_enable,
  input wire serial_interface_unit_fault,
  // Events
  input wire [N_DET-1:0] det_fault_report,
  input wire [N_DET-1:0] det_event,
  input wire [N_DET-1:0] det_reset,
  input wire slow_msg_request,
  input wire slow_msg_send,
  input wire frame0_slot,
  input wire frame0_send,
  input wire tod_send,
  input wire critical_fault,
  input wire flash
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int tod_gap_q;
  int det_gap_q;
  wire clr_cmd = awvalid && awready && wvalid && awaddr == 8'h04 && wdata[0];
  // Zero means no pulse seen yet
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tod_gap_q <= 0;
      det_gap_q <= 0;
    end
    else
    begin
      tod_gap_q <= tod_send ? 1 : tod_gap_q + (tod_gap_q != 0);
      det_gap_q <= det_reset[0] ? 1 : det_gap_q + (det_gap_q != 0);
    end
  end
  // Clear lands one cycle after its write edge
  sequence s_recent_clear;
    $past(clr_cmd, 1) || $past(clr_cmd, 2) || $past(clr_cmd, 3);
  endsequence
  chk_event_cause: assert property ((det_event & ~$past(det_fault_report)) == '0)
    else $error("detector event without report");
  chk_reset_spacing: assert property (det_reset[0] && det_gap_q != 0 |-> det_gap_q >= 20 * CLK_HZ)
    else $error("detector reset pulses too close");
  chk_reset_single: assert property (det_reset[0] |=> !det_reset[0])
    else $error("detector reset longer than one cycle");
  chk_slow_gate: assert property (slow_msg_send |-> slow_msg_request)
    else $error("slow message without request");
  chk_frame0_cause: assert property (frame0_send |-> $past(frame0_slot))
    else $error("frame zero outside slot");
  chk_tod_spacing: assert property (tod_send && tod_gap_q != 0 |-> tod_gap_q >= CLK_HZ)
    else $error("time of day sent twice in a second");
  chk_latch_release: assert property ($fell(critical_fault) |-> s_recent_clear)
    else $error("latched fault released without clear");
  chk_latch_flash: assert property (critical_fault |-> flash)
    else $error("latched fault without flash");
  // Latch entered from fault mode, or on a live bus fault
  chk_latch_cause: assert property ($rose(critical_fault) |-> $past(flash) ||
    $past(serial_interface_unit_fault) || $past(|(dev_poll_enable & ~dev_comm_ok)))
    else $error("fault latched without a bus fault");
endmodule // sdlcfs_checker

bind sdlcfs_top sdlcfs_checker #(.N_DEV(N_DEV), .N_DET(N_DET), .CLK_HZ(CLK_HZ)) i_sdlcfs_checker (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wvalid(wvalid), .dev_comm_ok(dev_comm_ok), .dev_poll_enable(dev_poll_enable),
  .serial_interface_unit_fault(serial_interface_unit_fault),
  .det_fault_report(det_fault_report), .det_event(det_event),
  .det_reset(det_reset), .slow_msg_request(slow_msg_request), .slow_msg_send(slow_msg_send),
  .frame0_slot(frame0_slot), .frame0_send(frame0_send), .tod_send(tod_send),
  .critical_fault(critical_fault), .flash(flash));

// file: sdlcfs_bus_model.sv
/* Far side: interface units, detector racks and monitor unit.
   Assumes the bench calls its tasks; each acts after a rising edge. */
`timescale 1ns/1ns
module sdlcfs_bus_model (
  // Clock
  input wire aclk,
  // Unit health
  output logic [16:0] dev_comm_ok,
  output logic [16:0] dev_frame_err,
  output logic serial_interface_unit_fault,
  // Detector racks
  output logic [7:0] det_fault_report,
  output logic [7:0] det_watchdog_fault,
  // Monitor unit
  output logic mmu_present,
  output logic [119:0] mmu_perm_cfg
);
  initial
  begin
    dev_comm_ok = '1;
    serial_interface_unit_fault = 0;
    {dev_frame_err, det_fault_report, det_watchdog_fault, mmu_present} = '0;
    mmu_perm_cfg = '0;
  end
  task link(input [16:0] ok, input logic s);
    @(posedge aclk);
    dev_comm_ok <= ok;
    serial_interface_unit_fault <= s;
  endtask
  // Single-cycle reports, never back to back
  task pulse(input [16:0] e, input [7:0] f);
    @(posedge aclk);
    dev_frame_err <= e;
    det_fault_report <= f;
    @(posedge aclk);
    dev_frame_err <= '0;
    det_fault_report <= '0;
  endtask
  task watchdog(input [7:0] w);
    @(posedge aclk);
    det_watchdog_fault <= w;
  endtask
  task monitor(input logic p, input [119:0] c);
    @(posedge aclk);
    mmu_present <= p;
    mmu_perm_cfg <= c;
  endtask
endmodule // sdlcfs_bus_model

// file: sdlc_fault_supervisor_tb_top.sv
/* Self-checking bench for the fault supervisor.
   Assumes the second tick shortened to 20 clocks. */
`timescale 1ns/1ns
module sdlc_fault_supervisor_tb_top;
  localparam int HZ = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow_msg_request, frame0_slot;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d, n;
  logic [1:0] r;
  logic [23:0] out_chan_state;
  wire awready, wready, bvalid, arready, rvalid, serial_interface_unit_fault, mmu_present;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [16:0] dev_comm_ok, dev_frame_err, dev_poll_enable;
  wire [7:0] det_fault_report, det_watchdog_fault, det_event, det_reset;
  wire slow_msg_send, frame0_send, tod_send, critical_fault, flash, chan_conflict;
  wire [15:0] frame0_chan;
  wire [119:0] mmu_perm_cfg;
  int fail_count, samples_checked;
  sdlcfs_top #(.CLK_HZ(HZ)) i_sdlcfs_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .dev_comm_ok, .dev_frame_err,
    .serial_interface_unit_fault, .dev_poll_enable, .det_fault_report, .det_watchdog_fault,
    .det_event, .det_reset, .slow_msg_request, .slow_msg_send, .frame0_slot, .out_chan_state,
    .frame0_send, .frame0_chan, .tod_send, .mmu_present, .mmu_perm_cfg, .critical_fault,
    .flash, .chan_conflict);
  sdlcfs_bus_model i_sdlcfs_bus_model (.aclk, .dev_comm_ok, .dev_frame_err,
    .serial_interface_unit_fault, .det_fault_report, .det_watchdog_fault, .mmu_present,
    .mmu_perm_cfg);
  ////////////////////////////////////////
  initial
  begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  // Tests take about 2600 clocks
  initial
  begin
    #500000;
    fail_count++;
    end_of_test;
  end
  task end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task ck(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task nw(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 0;
    wvalid <= 0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  ////////////////////////////////////////
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, slow_msg_request, frame0_slot} = '0;
    {awaddr, araddr, wdata, out_chan_state} = '0;
    aresetn = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00);
    ck(d, 32'h100);
    rd(8'hfc);
    ck(r, 2'b10);
    wr(8'hfc, 32'h0);
    ck(r, 2'b10);
    ck(dev_poll_enable, 0);
    wr(8'h0c, 32'h1_ffff);
    ck(r, 2'b00);
    wr(8'h00, 32'h2100);
    nw(1);
    ck(dev_poll_enable, 32'h1_ffff);
    i_sdlcfs_bus_model.link(17'h1_ffff, 1);
    nw(4);
    ck(critical_fault, 1);
    i_sdlcfs_bus_model.link(17'h1_ffff, 0);
    nw(4);
    ck(critical_fault, 1);
    wr(8'h04, 32'h1);
    nw(4);
    ck(critical_fault, 0);
    wr(8'h00, 32'h2101);
    for (int k = 0; k < 3; k++)
    begin
      i_sdlcfs_bus_model.link(17'h1_fffe, 0);
      nw(4);
      ck(flash, 1);
      ck(critical_fault, k == 2);
      i_sdlcfs_bus_model.link(17'h1_ffff, 0);
      nw(4);
      ck(flash, k == 2);
    end
    wr(8'h04, 32'h1);
    i_sdlcfs_bus_model.link(17'h1_fffe, 0);
    i_sdlcfs_bus_model.link(17'h1_ffff, 0);
    // One minute is 60 ticks of 20 clocks
    nw(1300);
    rd(8'h08);
    ck(d[5:4], 0);
    i_sdlcfs_bus_model.link(17'h1_fffe, 0);
    i_sdlcfs_bus_model.link(17'h1_ffff, 0);
    rd(8'h08);
    ck(d[5:4], 1);
    i_sdlcfs_bus_model.pulse(0, 8'h04);
    nw(1);
    ck(det_event, 8'h04);
    wr(8'h00, 32'h2000);
    i_sdlcfs_bus_model.pulse(0, 8'h04);
    nw(1);
    ck(det_event, 0);
    wr(8'h00, 32'h2200);
    i_sdlcfs_bus_model.watchdog(8'h01);
    n = 0;
    repeat (950)
    begin
      @(negedge aclk);
      n += det_reset[0];
    end
    ck(n, 3);
    i_sdlcfs_bus_model.watchdog(0);
    wr(8'h00, 32'h2400);
    slow_msg_request <= 1;
    nw(1);
    ck(slow_msg_send, 0);
    wr(8'h00, 32'h2000);
    nw(1);
    ck(slow_msg_send, 1);
    wr(8'h20, 32'h05);
    wr(8'h00, 32'h2800);
    out_chan_state <= 24'h12;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge aclk);
      frame0_slot <= 1;
      @(posedge aclk);
      frame0_slot <= 0;
      nw(1);
      ck(frame0_send, k == 0);
      if (k == 0) ck(frame0_chan, 16'h0013);
      wr(8'h00, 32'h2000);
    end
    for (int k = 1; k >= 0; k--)
    begin
      wr(8'h00, k ? 32'h3000 : 32'h2000);
      n = 0;
      repeat (100)
      begin
        @(negedge aclk);
        n += tod_send;
      end
      ck(n, k * 5);
    end
    ck(chan_conflict, 1);
    i_sdlcfs_bus_model.monitor(1, 120'h2_0009);
    wr(8'h10, 32'h2_0009);
    wr(8'h04, 32'h1);
    nw(4);
    ck(chan_conflict, 0);
    ck(flash, 0);
    i_sdlcfs_bus_model.monitor(1, 120'h2_000b);
    nw(4);
    ck(flash, 1);
    i_sdlcfs_bus_model.monitor(1, 120'h2_0009);
    wr(8'h04, 32'h1);
    nw(4);
    ck(flash, 0);
    repeat (3) i_sdlcfs_bus_model.pulse(17'h8, 0);
    rd(8'h4c);
    ck(d, 3);
    wr(8'h04, 32'h2);
    rd(8'h4c);
    ck(d, 0);
    i_sdlcfs_bus_model.link(17'h1_7fff, 0);
    rd(8'h30);
    ck(d, 32'h1_7fff);
    end_of_test;
  end
endmodule // sdlc_fault_supervisor_tb_top
